// [design/dtm_map.svh]
// Register indices, field positions, reset values and counts of the timer pair
`ifndef DTM_MAP_SVH
`define DTM_MAP_SVH

`define DTM_IDX_A_MODE     10'h0D8
`define DTM_IDX_A_COUNT    10'h0D9
`define DTM_IDX_B_MODE     10'h0DC
`define DTM_IDX_B_COUNT    10'h0DD
`define DTM_IDX_B_RELOAD   10'h0DE
`define DTM_IDX_IRQ_CTRL   10'h0E0
`define DTM_IDX_B_STATUS   10'h0E1

`define DTM_BIT_RUN        7
`define DTM_RATE_HI        6
`define DTM_RATE_LO        4
`define DTM_BIT_SRC        3
`define DTM_BIT_RELOAD     2
`define DTM_BIT_TOGGLE     1
`define DTM_BIT_PWM        0

`define DTM_BIT_A_IEN      0
`define DTM_BIT_A_FLAG     1
`define DTM_BIT_B_IEN      2
`define DTM_BIT_B_FLAG     3
`define DTM_BIT_EXT_FLAG   4

`define DTM_RST_BYTE       8'h00
`define DTM_MAX_COUNT      8'hFF
`define DTM_MASK_256       8'hFF
`define DTM_MASK_64        8'h3F
`define DTM_MASK_32        8'h1F
`define DTM_MASK_16        8'h0F
`define DTM_PIN_IDLE       1'b1

`define DTM_RESP_OKAY      2'h0
`define DTM_RESP_SLVERR    2'h2

`endif

// [design/dtm_pkg.sv]
// Shared types of the timer pair
package dtm_pkg;
  typedef logic [7:0] dtm_byte_t;
  typedef logic [9:0] dtm_index_t;
  typedef enum logic [1:0] {
    DTM_BOUND_256,
    DTM_BOUND_64,
    DTM_BOUND_32,
    DTM_BOUND_16
  } dtm_bound_t;
endpackage : dtm_pkg

// [design/dtm_evt_if.sv]
// Count enables passed from prescaler and pin sampler to the timer core
`timescale 1ns/10ps
interface dtm_evt_if;
  logic [7:0] tick;
  logic       ext_fall;
  modport prescale (output tick);
  modport edge_src (output ext_fall);
  modport core     (input tick, input ext_fall);
endinterface : dtm_evt_if

// [design/dtm_prescaler.sv]
// Free-running divider giving one-cycle enables at clock/2 up to clock/256
`timescale 1ns/10ps
`include "dtm_map.svh"
module dtm_prescaler (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  dtm_evt_if.prescale evt
);
  logic [7:0] div_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_reg <= `DTM_RST_BYTE;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Enable k fires once every 2^(k+1) cycles
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      evt.tick[k] = &(div_reg | ~8'((9'h002 << k) - 9'h001));
    end
  end
endmodule : dtm_prescaler

// [design/dtm_edge_sync.sv]
// Event pin synchroniser with falling-edge pulse
`timescale 1ns/10ps
`include "dtm_map.svh"
module dtm_edge_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  dtm_evt_if.edge_src evt
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= `DTM_PIN_IDLE;
      sync_reg <= `DTM_PIN_IDLE;
      last_reg <= `DTM_PIN_IDLE;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign evt.ext_fall = last_reg & ~sync_reg;
endmodule : dtm_edge_sync

// [design/dtm_top.sv]
// Two 8-bit up timers with AXI4-Lite register access
//
// Functional notes
// - Timer A counts up, wraps FF to 00, keeps counting, raises its request.
// - Timer A overflow while running wakes the system from green mode.
// - Timer A mode bit 7 stops (0) or runs (1) the counter.
// - Timer A mode bits 6:4 pick clock/256 (000) down to clock/2 (111).
// - Timer A count is 8-bit read/write, resets to 0, interval 256 minus preload.
// - Timer B counts prescaled clock or falling edges of the event pin.
// - Timer B outside PWM overflows FF to 00, keeps counting, raises request.
// - Timer B mode bit 3 selects internal (0) or event pin (1) clock.
// - With the event pin selected, rate is ignored and pin flag stays 0.
// - Timer B mode bits 6:4 pick clock/256 (000) down to clock/2 (111).
// - Timer B mode bit 7 stops (0) or runs (1) the counter.
// - Timer B mode bit 0 enables PWM; reload and toggle bits pick period.
// - Without PWM, bit 1 drives overflow toggle on buzzer pin, else pin free.
// - Without PWM, bit 2 enables auto-reload.
// - Internal clock with PWM: boundary 256, 64, 32 or 16; otherwise 256.
// - Timer B count is 8-bit read/write, resets 0, interval boundary minus preload.
// - With auto-reload, overflow copies the reload value into the count.
// - Reload writes go to a buffer taken over at the next overflow.
// - PWM forces auto-reload; the reload bit then only picks the boundary.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`include "dtm_map.svh"
module dtm_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic [11:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [11:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        EVENT_PIN_I,
  output logic             BUZZER_PIN_O,
  output logic             BUZZER_PIN_OE_O,
  output logic             TIMER_A_IRQ_O,
  output logic             TIMER_B_IRQ_O,
  output logic             EXT_PIN_IRQ_O,
  output logic             WAKEUP_O
);

  dtm_evt_if evt ();

  dtm_prescaler u_prescaler (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .evt     (evt.prescale)
  );

  dtm_edge_sync u_edge_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .pin_i   (EVENT_PIN_I),
    .evt     (evt.edge_src)
  );

  // Rate code 000 -> clock/256, 111 -> clock/2
  function automatic logic rate_tick(input logic [2:0] code, input logic [7:0] tick);
    rate_tick = tick[3'h7 - code];
  endfunction : rate_tick

  function automatic dtm_pkg::dtm_byte_t bound_mask(input dtm_pkg::dtm_bound_t b);
    case (b)
      dtm_pkg::DTM_BOUND_64: bound_mask = `DTM_MASK_64;
      dtm_pkg::DTM_BOUND_32: bound_mask = `DTM_MASK_32;
      dtm_pkg::DTM_BOUND_16: bound_mask = `DTM_MASK_16;
      default:               bound_mask = `DTM_MASK_256;
    endcase
  endfunction : bound_mask

  dtm_pkg::dtm_byte_t  a_mode_reg;
  dtm_pkg::dtm_byte_t  a_count_reg;
  dtm_pkg::dtm_byte_t  b_mode_reg;
  dtm_pkg::dtm_byte_t  b_count_reg;
  dtm_pkg::dtm_byte_t  b_reload_buf_reg;
  dtm_pkg::dtm_byte_t  b_reload_act_reg;
  logic                a_irq_en_reg;
  logic                b_irq_en_reg;
  logic                a_flag_reg;
  logic                b_flag_reg;
  logic                ext_flag_reg;
  logic                toggle_reg;

  logic                aw_full_reg;
  logic                w_full_reg;
  dtm_pkg::dtm_index_t aw_index_reg;
  dtm_pkg::dtm_byte_t  w_byte_reg;
  logic                w_lane_reg;
  logic                wr_fire;
  logic                wr_lane;
  logic                wr_mapped;
  dtm_pkg::dtm_index_t rd_index;
  dtm_pkg::dtm_byte_t  rd_byte;
  logic                rd_mapped;

  logic                a_run;
  logic                a_step;
  logic                a_ovf;
  logic                b_run;
  logic                b_src_ext;
  logic                b_pwm;
  logic                b_reload_on;
  logic                b_step;
  logic                b_ovf;
  dtm_pkg::dtm_bound_t b_bound;
  dtm_pkg::dtm_byte_t  b_mask;
  logic                a_flag_next;
  logic                b_flag_next;
  logic                ext_flag_next;

  // Write path: address and data taken in either order
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      aw_full_reg     <= 1'b0;
      aw_index_reg    <= '0;
      S_AXI_AWREADY_O <= 1'b0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_full_reg     <= 1'b1;
      aw_index_reg    <= S_AXI_AWADDR_I[11:2];
      S_AXI_AWREADY_O <= 1'b0;
    end else if (wr_fire) begin
      aw_full_reg     <= 1'b0;
    end else if (!aw_full_reg && !S_AXI_BVALID_O) begin
      S_AXI_AWREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      w_full_reg     <= 1'b0;
      w_byte_reg     <= `DTM_RST_BYTE;
      w_lane_reg     <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_full_reg     <= 1'b1;
      w_byte_reg     <= S_AXI_WDATA_I[7:0];
      w_lane_reg     <= S_AXI_WSTRB_I[0];
      S_AXI_WREADY_O <= 1'b0;
    end else if (wr_fire) begin
      w_full_reg     <= 1'b0;
    end else if (!w_full_reg && !S_AXI_BVALID_O) begin
      S_AXI_WREADY_O <= 1'b1;
    end
  end

  assign wr_fire = aw_full_reg && w_full_reg && !S_AXI_BVALID_O;
  assign wr_lane = wr_fire && w_lane_reg;

  always_comb begin
    if (aw_index_reg == `DTM_IDX_A_MODE || aw_index_reg == `DTM_IDX_A_COUNT) begin
      wr_mapped = 1'b1;
    end else if (aw_index_reg == `DTM_IDX_B_MODE || aw_index_reg == `DTM_IDX_B_COUNT) begin
      wr_mapped = 1'b1;
    end else if (aw_index_reg == `DTM_IDX_B_RELOAD || aw_index_reg == `DTM_IDX_IRQ_CTRL) begin
      wr_mapped = 1'b1;
    end else if (aw_index_reg == `DTM_IDX_B_STATUS) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= `DTM_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wr_mapped ? `DTM_RESP_OKAY : `DTM_RESP_SLVERR;
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // Read path: data one cycle after the address is taken
  assign rd_index = S_AXI_ARADDR_I[11:2];

  always_comb begin
    rd_mapped = 1'b1;
    if (rd_index == `DTM_IDX_A_MODE) begin
      rd_byte = a_mode_reg;
    end else if (rd_index == `DTM_IDX_A_COUNT) begin
      rd_byte = a_count_reg;
    end else if (rd_index == `DTM_IDX_B_MODE) begin
      rd_byte = b_mode_reg;
    end else if (rd_index == `DTM_IDX_B_COUNT) begin
      rd_byte = b_count_reg;
    end else if (rd_index == `DTM_IDX_B_RELOAD) begin
      rd_byte = `DTM_RST_BYTE;
    end else if (rd_index == `DTM_IDX_IRQ_CTRL) begin
      rd_byte = {3'h0, ext_flag_reg, b_flag_reg, b_irq_en_reg, a_flag_reg, a_irq_en_reg};
    end else if (rd_index == `DTM_IDX_B_STATUS) begin
      rd_byte = b_reload_act_reg;
    end else begin
      rd_byte   = `DTM_RST_BYTE;
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= '0;
      S_AXI_RRESP_O   <= `DTM_RESP_OKAY;
    end else if (S_AXI_RVALID_O) begin
      if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b1;
      S_AXI_RDATA_O   <= {24'h000000, rd_byte};
      S_AXI_RRESP_O   <= rd_mapped ? `DTM_RESP_OKAY : `DTM_RESP_SLVERR;
    end else begin
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // Mode and enable registers
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      a_mode_reg       <= `DTM_RST_BYTE;
      b_mode_reg       <= `DTM_RST_BYTE;
      a_irq_en_reg     <= 1'b0;
      b_irq_en_reg     <= 1'b0;
      b_reload_buf_reg <= `DTM_RST_BYTE;
    end else if (wr_lane) begin
      // Timer A keeps run and rate bits; reserved low bits cleared
      if (aw_index_reg == `DTM_IDX_A_MODE) begin
        a_mode_reg <= {w_byte_reg[7:4], 4'h0};
      end else if (aw_index_reg == `DTM_IDX_B_MODE) begin
        b_mode_reg <= w_byte_reg;
      end else if (aw_index_reg == `DTM_IDX_B_RELOAD) begin
        // Writes land in the holding buffer
        b_reload_buf_reg <= w_byte_reg;
      end else if (aw_index_reg == `DTM_IDX_IRQ_CTRL) begin
        a_irq_en_reg <= w_byte_reg[`DTM_BIT_A_IEN];
        b_irq_en_reg <= w_byte_reg[`DTM_BIT_B_IEN];
      end
    end
  end

  // Timer A
  assign a_run = a_mode_reg[`DTM_BIT_RUN];
  assign a_step = a_run && rate_tick(a_mode_reg[`DTM_RATE_HI:`DTM_RATE_LO], evt.tick);
  assign a_ovf = a_step && (a_count_reg == `DTM_MAX_COUNT);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      a_count_reg <= `DTM_RST_BYTE;
    end else if (wr_lane && aw_index_reg == `DTM_IDX_A_COUNT) begin
      a_count_reg <= w_byte_reg;
    end else if (a_step) begin
      a_count_reg <= a_count_reg + 8'h01;
    end
  end

  // Timer B
  assign b_run       = b_mode_reg[`DTM_BIT_RUN];
  assign b_src_ext   = b_mode_reg[`DTM_BIT_SRC];
  assign b_pwm       = b_mode_reg[`DTM_BIT_PWM];
  assign b_reload_on = b_pwm || b_mode_reg[`DTM_BIT_RELOAD];

  assign b_step = b_run && (b_src_ext ? evt.ext_fall
                                      : rate_tick(b_mode_reg[`DTM_RATE_HI:`DTM_RATE_LO], evt.tick));

  // Boundary from reload and toggle bits under internal PWM
  always_comb begin
    if (b_pwm && !b_src_ext) begin
      case ({b_mode_reg[`DTM_BIT_RELOAD], b_mode_reg[`DTM_BIT_TOGGLE]})
        2'b01:   b_bound = dtm_pkg::DTM_BOUND_64;
        2'b10:   b_bound = dtm_pkg::DTM_BOUND_32;
        2'b11:   b_bound = dtm_pkg::DTM_BOUND_16;
        default: b_bound = dtm_pkg::DTM_BOUND_256;
      endcase
    end else begin
      b_bound = dtm_pkg::DTM_BOUND_256;
    end
  end

  assign b_mask = bound_mask(b_bound);
  assign b_ovf  = b_step && ((b_count_reg & b_mask) == b_mask);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      b_count_reg <= `DTM_RST_BYTE;
    end else if (wr_lane && aw_index_reg == `DTM_IDX_B_COUNT) begin
      b_count_reg <= w_byte_reg;
    end else if (b_ovf) begin
      b_count_reg <= b_reload_on ? b_reload_buf_reg : `DTM_RST_BYTE;
    end else if (b_step) begin
      b_count_reg <= b_count_reg + 8'h01;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      b_reload_act_reg <= `DTM_RST_BYTE;
    end else if (b_ovf) begin
      b_reload_act_reg <= b_reload_buf_reg;
    end
  end

  // Buzzer pin toggles on each overflow while driven
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      toggle_reg      <= 1'b0;
      BUZZER_PIN_O    <= 1'b0;
      BUZZER_PIN_OE_O <= 1'b0;
    end else begin
      if (b_ovf) begin
        toggle_reg <= ~toggle_reg;
      end
      BUZZER_PIN_O    <= toggle_reg;
      BUZZER_PIN_OE_O <= b_pwm || b_mode_reg[`DTM_BIT_TOGGLE];
    end
  end

  always_comb begin
    a_flag_next   = a_flag_reg;
    b_flag_next   = b_flag_reg;
    ext_flag_next = ext_flag_reg;
    if (wr_lane && aw_index_reg == `DTM_IDX_IRQ_CTRL) begin
      a_flag_next   = a_flag_reg & ~w_byte_reg[`DTM_BIT_A_FLAG];
      b_flag_next   = b_flag_reg & ~w_byte_reg[`DTM_BIT_B_FLAG];
      ext_flag_next = ext_flag_reg & ~w_byte_reg[`DTM_BIT_EXT_FLAG];
    end
    if (a_ovf) begin
      a_flag_next = 1'b1;
    end
    if (b_ovf) begin
      b_flag_next = 1'b1;
    end
    if (evt.ext_fall) begin
      ext_flag_next = 1'b1;
    end
    // Pin flag held low in event-count mode
    if (b_src_ext) begin
      ext_flag_next = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      a_flag_reg    <= 1'b0;
      b_flag_reg    <= 1'b0;
      ext_flag_reg  <= 1'b0;
      TIMER_A_IRQ_O <= 1'b0;
      TIMER_B_IRQ_O <= 1'b0;
      EXT_PIN_IRQ_O <= 1'b0;
    end else begin
      a_flag_reg    <= a_flag_next;
      b_flag_reg    <= b_flag_next;
      ext_flag_reg  <= ext_flag_next;
      TIMER_A_IRQ_O <= a_flag_next && a_irq_en_reg;
      TIMER_B_IRQ_O <= b_flag_next && b_irq_en_reg;
      EXT_PIN_IRQ_O <= ext_flag_next;
    end
  end

  // Wake-up pulse on timer A overflow
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      WAKEUP_O <= 1'b0;
    end else begin
      WAKEUP_O <= a_ovf;
    end
  end

endmodule : dtm_top

// [tb/dtm_top_asserts.sv]
// Port-level checks of the timer pair, bound to its top module
`timescale 1ns/10ps
module dtm_top_chk (
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        EVENT_PIN_I,
  input wire logic        BUZZER_PIN_OE_O,
  input wire logic        TIMER_A_IRQ_O,
  input wire logic        TIMER_B_IRQ_O,
  input wire logic        EXT_PIN_IRQ_O,
  input wire logic        WAKEUP_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  property p_wake_pulse; WAKEUP_O |=> !WAKEUP_O; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wakeup pulse too wide");
  property p_a_irq_hold;
    $fell(TIMER_A_IRQ_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O);
  endproperty
  a_a_irq_hold: assert property (p_a_irq_hold) else $error("timer a request lost");
  property p_b_irq_hold;
    $fell(TIMER_B_IRQ_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O);
  endproperty
  a_b_irq_hold: assert property (p_b_irq_hold) else $error("timer b request lost");
  property p_oe_cause;
    $changed(BUZZER_PIN_OE_O) |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("buzzer enable moved alone");
  property p_ext_cause; $rose(EXT_PIN_IRQ_O) |-> !$past(EVENT_PIN_I, 2); endproperty
  a_ext_cause: assert property (p_ext_cause) else $error("pin flag without edge");
  property p_write_ans;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
      |-> ##[1:2] S_AXI_BVALID_O;
  endproperty
  a_write_ans: assert property (p_write_ans) else $error("write not answered");
  property p_b_once; S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_read_ans;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
  endproperty
  a_read_ans: assert property (p_read_ans) else $error("read not answered");
  property p_rdata_hi; S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000; endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");
endmodule : dtm_top_chk

bind dtm_top dtm_top_chk i_chk (.CLOCK_I, .RST_N_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
  .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
  .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O, .EVENT_PIN_I, .BUZZER_PIN_OE_O,
  .TIMER_A_IRQ_O, .TIMER_B_IRQ_O, .EXT_PIN_IRQ_O, .WAKEUP_O);

// [tb/dtm_pin_model.sv]
// Event pin source and buzzer pin watcher outside the timer pair
`timescale 1ns/10ps
module dtm_pin_model (
  input  wire logic clk_i,
  input  wire logic buzz_i,
  output logic      pin_o
);
  initial pin_o = 1'b1;
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
  endtask : edges
  // Cycles until the buzzer level flips
  task automatic wait_flip(output int n);
    logic b;
    b = buzz_i;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (buzz_i === b && n < 2000);
  endtask : wait_flip
endmodule : dtm_pin_model

// [tb/testbench.sv]
// Self-checking bench for the timer pair
`timescale 1ns/10ps
`include "dtm_map.svh"
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bready = 1'b0;
  logic        arv = 1'b0;
  logic        rready = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid;
  logic        pin, buzz, oe, irq_a, irq_b, irq_e, wake;
  logic [33:0] exp_q[$];
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          wake_cnt = 0;
  logic [9:0]  regs [4] = '{`DTM_IDX_A_MODE, `DTM_IDX_A_COUNT, `DTM_IDX_B_MODE,
                            `DTM_IDX_B_COUNT};
  logic [2:0]  cfg [6] = '{3'b001, 3'b011, 3'b101, 3'b111, 3'b110, 3'b010};
  int          bnd [6] = '{256, 64, 32, 16, 256, 256};

  always #10 clk = ~clk;

  dtm_top i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .EVENT_PIN_I(pin), .BUZZER_PIN_O(buzz),
    .BUZZER_PIN_OE_O(oe), .TIMER_A_IRQ_O(irq_a), .TIMER_B_IRQ_O(irq_b),
    .EXT_PIN_IRQ_O(irq_e), .WAKEUP_O(wake));

  dtm_pin_model i_pin (.clk_i(clk), .buzz_i(buzz), .pin_o(pin));

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] r = 2'h0);
    logic a, w;
    exp_q.push_back({r, 32'h00000000});
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    while (a || w) begin
      @(posedge clk);
      if (a && awrdy) begin
        a = 1'b0;
        awv <= 1'b0;
      end
      if (w && wrdy) begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, 24'h000000, d});
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  task automatic wait_a(output int n);
    n = 0;
    while (!irq_a && n < 40000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_a

  // Answers compared in issue order
  always @(posedge clk) begin
    if (bvalid && bready) check({bresp, 32'h00000000}, exp_q.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake) wake_cnt <= wake_cnt + 1;
    if (cyc == 60000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    int n, div, w0;
    logic [7:0] x, r, prev;
    logic ld;
    void'($urandom(317));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(10'h0FF, 8'h5A, `DTM_RESP_SLVERR);
    rd(10'h0FF, 8'h00, `DTM_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      x = 8'($urandom) & 8'h7F;
      wr(regs[i], x);
      rd(regs[i], (i == 0) ? (x & 8'h70) : x);
    end
    wr(`DTM_IDX_B_MODE, 8'h00);
    for (int c = 0; c < 8; c++) begin
      // stop, clear, rate, load, enable, run
      wr(`DTM_IDX_A_MODE, 8'h00);
      wr(`DTM_IDX_IRQ_CTRL, 8'h02);
      wr(`DTM_IDX_A_MODE, {1'b0, 3'(c), 4'h0});
      wr(`DTM_IDX_A_COUNT, 8'd252);
      wr(`DTM_IDX_IRQ_CTRL, 8'h01);
      wr(`DTM_IDX_A_MODE, {1'b1, 3'(c), 4'h0});
      div = 256 >> c;
      w0 = wake_cnt;
      wait_a(n);
      check(34'(n >= 3 * div && n <= 4 * div + 8), 34'h1);
      repeat (2) @(posedge clk);
      check(34'(wake_cnt - w0), 34'h1);
    end
    wr(`DTM_IDX_IRQ_CTRL, 8'h03);
    @(negedge clk);
    check(34'(irq_a), 34'h0);
    wait_a(n);
    check(34'(n >= 470 && n <= 520), 34'h1);
    wr(`DTM_IDX_A_MODE, 8'h00);
    x = 8'($urandom);
    wr(`DTM_IDX_A_COUNT, x);
    w0 = wake_cnt;
    repeat (600) @(posedge clk);
    rd(`DTM_IDX_A_COUNT, x);
    check(34'(wake_cnt - w0), 34'h0);
    wr(`DTM_IDX_IRQ_CTRL, 8'h06);
    prev = 8'h00;
    for (int e = 0; e < 6; e++) begin
      wr(`DTM_IDX_B_MODE, 8'h00);
      wr(`DTM_IDX_B_COUNT, 8'h00);
      r = 8'($urandom % bnd[e]);
      wr(`DTM_IDX_B_RELOAD, r);
      rd(`DTM_IDX_B_STATUS, prev);
      wr(`DTM_IDX_B_MODE, {4'hF, 1'b0, cfg[e]});
      @(negedge clk);
      check(34'(oe), 34'h1);
      i_pin.wait_flip(n);
      i_pin.wait_flip(n);
      ld = cfg[e][2] | cfg[e][0];
      check(34'(n), 34'(ld ? (bnd[e] - r) * 2 : bnd[e] * 2));
      if (ld) begin
        rd(`DTM_IDX_B_STATUS, r);
        prev = r;
      end
    end
    wr(`DTM_IDX_B_MODE, 8'hF4);
    @(negedge clk);
    check(34'(oe), 34'h0);
    check(34'(irq_b), 34'h1);
    wr(`DTM_IDX_B_MODE, 8'h00);
    wr(`DTM_IDX_IRQ_CTRL, 8'h1A);
    wr(`DTM_IDX_B_COUNT, 8'h00);
    wr(`DTM_IDX_B_MODE, 8'hF8);
    i_pin.edges(5);
    rd(`DTM_IDX_B_COUNT, 8'h05);
    rd(`DTM_IDX_IRQ_CTRL, 8'h00);
    wr(`DTM_IDX_B_MODE, 8'h00);
    i_pin.edges(1);
    @(negedge clk);
    check(34'(irq_e), 34'h1);
    rd(`DTM_IDX_B_COUNT, 8'h05);
    rd(`DTM_IDX_IRQ_CTRL, 8'h10);
    close_out();
  end
endmodule : testbench
